/* File: gpp_pkg.sv */
// package for the eight-bit general purpose io port
// assumes a single 50 MHz clock and a plain register port
package gpp_pkg;

   // ==========================================================
   // sizes and register offsets
   localparam int WIDTH = 8;
   localparam logic [3:0] OFF_DATA = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h1;
   localparam logic [3:0] OFF_MODE_LO = 4'h2;
   localparam logic [3:0] OFF_MODE_HI = 4'h3;
   localparam logic [3:0] OFF_MODE_TOP = 4'h4;
   localparam logic [3:0] OFF_SYNC = 4'h5;
   localparam logic [3:0] OFF_IRQ_STAT = 4'h6;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h7;
   localparam logic [3:0] OFF_IRQ_CLEAR = 4'h8;
   localparam logic [3:0] OFF_EDGE_SEL = 4'h9;

   // ==========================================================
   // reset values and locked-pin mask
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_SYNC = 8'h00;
   localparam logic [7:0] RST_EDGE = 8'h00;
   localparam logic [7:0] LOCK_MASK = 8'hC0;

   // ==========================================================
   // drive modes, three bits per pin
   typedef enum logic [2:0] {
      drive_analog_highz = 3'h0,
      drive_digital_highz = 3'h1,
      drive_resistive_pullup = 3'h2,
      drive_resistive_pulldown = 3'h3,
      drive_open_drain_low = 3'h4,
      drive_open_drain_high = 3'h5,
      drive_push_pull = 3'h6,
      drive_resistive_pull_both = 3'h7
   } gpp_mode_type;
   localparam logic [2:0] RST_MODE = 3'h0;

   // ==========================================================
   // per-pin pad controls and register bus
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull_up;
      logic [7:0] pull_down;
      logic [7:0] in_en;
   } gpp_pad_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } gpp_bus_type;

endpackage : gpp_pkg

/* File: gpp_pad_ctl.sv */
// translates data bit and drive mode into pad controls for one pin
// assumes the pad resolves out, oe and pull enables into a level
`timescale 1ns/10ps
module gpp_pad_ctl (
   input wire logic data_i,
   input wire logic [2:0] mode_i,
   output logic out_o,
   output logic oe_o,
   output logic pull_up_o,
   output logic pull_down_o,
   output logic in_en_o
);
   // ==========================================================
   // mode decode
   always_comb begin
      out_o = data_i;
      oe_o = 1'b0;
      pull_up_o = 1'b0;
      pull_down_o = 1'b0;
      in_en_o = 1'b1;
      unique case (gpp_pkg::gpp_mode_type'(mode_i))
         gpp_pkg::drive_analog_highz: begin
            in_en_o = 1'b0;
         end
         gpp_pkg::drive_digital_highz: begin
         end
         gpp_pkg::drive_resistive_pullup: begin
            // strong low, resistive high
            oe_o = ~data_i;
            pull_up_o = data_i;
         end
         gpp_pkg::drive_resistive_pulldown: begin
            oe_o = data_i;
            pull_down_o = ~data_i;
         end
         gpp_pkg::drive_open_drain_low: begin
            oe_o = ~data_i;
         end
         gpp_pkg::drive_open_drain_high: begin
            oe_o = data_i;
         end
         gpp_pkg::drive_push_pull: begin
            oe_o = 1'b1;
         end
         gpp_pkg::drive_resistive_pull_both: begin
            pull_up_o = data_i;
            pull_down_o = ~data_i;
         end
      endcase
   end
endmodule : gpp_pad_ctl

/* File: gpp_port.sv */
// eight-bit general purpose io port with register port and interrupt
// assumes pin inputs synchronous to sys_clk_i; one strobe per cycle
//
// How it works
// - status read returns sensed pin levels
// - data bit sets driven value per mode
// - data register reads back last write
// - eight drive modes per pin
// - one interrupt status bit per pin
// - clear empties whole interrupt status register
// - locked revision: top two pins ignore data and mode writes
// - sync option registers output before pin
// - port holds at most eight pins
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module gpp_port #(
   parameter bit LOCK_TOP = 1'b0
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [7:0] pin_i,
   output logic [7:0] pin_out_o,
   output logic [7:0] pin_oe_o,
   output logic [7:0] pull_up_o,
   output logic [7:0] pull_down_o,
   output logic [7:0] in_en_o,
   output logic irq_o
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0] data;
      logic [23:0] mode;
      logic [7:0] sync;
      logic [7:0] stat;
      logic [7:0] mask;
      logic [7:0] edge_sel;
      logic [7:0] pin_prev;
      logic [7:0] rdata;
      // decode stage; synchronised pins take their outputs from here
      gpp_pkg::gpp_pad_type dec;
      gpp_pkg::gpp_pad_type pad;
      logic irq;
   } gpp_state_type;

   gpp_state_type state_r;
   gpp_state_type state_nxt;
   gpp_pkg::gpp_bus_type bus;
   gpp_pkg::gpp_pad_type pad_comb;
   logic [7:0] wmask;
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] event_v;

   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
   // locked pins keep their reset data and mode whatever software writes
   assign wmask = LOCK_TOP ? ~gpp_pkg::LOCK_MASK : 8'hFF;

   // ==========================================================
   // per-pin pad decode
   genvar g;
   generate
      for (g = 0; g < gpp_pkg::WIDTH; g++) begin : g_pin
         gpp_pad_ctl u_pad (
            .data_i(state_r.data[g]),
            .mode_i(state_r.mode[3*g +: 3]),
            .out_o(pad_comb.out[g]),
            .oe_o(pad_comb.oe[g]),
            .pull_up_o(pad_comb.pull_up[g]),
            .pull_down_o(pad_comb.pull_down[g]),
            .in_en_o(pad_comb.in_en[g])
         );
      end
   endgenerate

   // ==========================================================
   // pin events: edge_sel 1 = falling, 0 = rising
   assign rise = pin_i & ~state_r.pin_prev;
   assign fall = ~pin_i & state_r.pin_prev;
   // analog pins have no digital input, so they raise no events
   assign event_v = ((state_r.edge_sel & fall) | (~state_r.edge_sel & rise))
      & pad_comb.in_en;

   // ==========================================================
   // next state
   always_comb begin
      state_nxt = state_r;
      state_nxt.pin_prev = pin_i;
      state_nxt.rdata = 8'h00;
      if (bus.wr) begin
         unique case (bus.addr)
            gpp_pkg::OFF_DATA: state_nxt.data =
               (state_r.data & ~wmask) | (bus.wdata & wmask);
            gpp_pkg::OFF_MODE_LO: begin
               for (int i = 0; i < 8; i++) begin
                  if (wmask[i]) state_nxt.mode[3*i] = bus.wdata[i];
               end
            end
            gpp_pkg::OFF_MODE_HI: begin
               for (int i = 0; i < 8; i++) begin
                  if (wmask[i]) state_nxt.mode[3*i+1] = bus.wdata[i];
               end
            end
            gpp_pkg::OFF_MODE_TOP: begin
               for (int i = 0; i < 8; i++) begin
                  if (wmask[i]) state_nxt.mode[3*i+2] = bus.wdata[i];
               end
            end
            gpp_pkg::OFF_SYNC: state_nxt.sync = bus.wdata;
            gpp_pkg::OFF_IRQ_MASK: state_nxt.mask = bus.wdata;
            gpp_pkg::OFF_EDGE_SEL: state_nxt.edge_sel = bus.wdata;
            gpp_pkg::OFF_IRQ_STAT: state_nxt.stat = state_r.stat & ~bus.wdata;
            // any write here wipes every pending bit of the port
            gpp_pkg::OFF_IRQ_CLEAR: state_nxt.stat = 8'h00;
            default: begin
            end
         endcase
      end
      if (bus.rd) begin
         unique case (bus.addr)
            gpp_pkg::OFF_DATA: state_nxt.rdata = state_r.data;
            gpp_pkg::OFF_STATUS: state_nxt.rdata = pin_i;
            gpp_pkg::OFF_MODE_LO: begin
               for (int i = 0; i < 8; i++) begin
                  state_nxt.rdata[i] = state_r.mode[3*i];
               end
            end
            gpp_pkg::OFF_MODE_HI: begin
               for (int i = 0; i < 8; i++) begin
                  state_nxt.rdata[i] = state_r.mode[3*i+1];
               end
            end
            gpp_pkg::OFF_MODE_TOP: begin
               for (int i = 0; i < 8; i++) begin
                  state_nxt.rdata[i] = state_r.mode[3*i+2];
               end
            end
            gpp_pkg::OFF_SYNC: state_nxt.rdata = state_r.sync;
            gpp_pkg::OFF_IRQ_STAT: state_nxt.rdata = state_r.stat;
            gpp_pkg::OFF_IRQ_MASK: state_nxt.rdata = state_r.mask;
            gpp_pkg::OFF_EDGE_SEL: state_nxt.rdata = state_r.edge_sel;
            // read of the clear register returns status, then clears
            gpp_pkg::OFF_IRQ_CLEAR: begin
               state_nxt.rdata = state_r.stat;
               state_nxt.stat = 8'h00;
            end
            default: state_nxt.rdata = 8'h00;
         endcase
      end
      // set wins over clear in the same cycle
      state_nxt.stat = state_nxt.stat | event_v;
      // unsynchronised pins take the decode directly; sync adds a stage
      // so that all synchronised pins of the port switch on one edge
      state_nxt.dec = pad_comb;
      state_nxt.pad.out = (state_r.sync & state_r.dec.out)
         | (~state_r.sync & pad_comb.out);
      state_nxt.pad.oe = (state_r.sync & state_r.dec.oe)
         | (~state_r.sync & pad_comb.oe);
      state_nxt.pad.pull_up = (state_r.sync & state_r.dec.pull_up)
         | (~state_r.sync & pad_comb.pull_up);
      state_nxt.pad.pull_down = (state_r.sync & state_r.dec.pull_down)
         | (~state_r.sync & pad_comb.pull_down);
      // input enable is not synchronised: it only gates the sensing side
      state_nxt.pad.in_en = pad_comb.in_en;
      state_nxt.irq = |(state_nxt.stat & state_nxt.mask);
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= '0;
         state_r.data <= gpp_pkg::RST_DATA;
         state_r.mask <= gpp_pkg::RST_MASK;
         state_r.sync <= gpp_pkg::RST_SYNC;
         state_r.edge_sel <= gpp_pkg::RST_EDGE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // outputs, each straight from a flip-flop of the state
   assign pin_out_o = state_r.pad.out;
   assign pin_oe_o = state_r.pad.oe;
   assign pull_up_o = state_r.pad.pull_up;
   assign pull_down_o = state_r.pad.pull_down;
   assign in_en_o = state_r.pad.in_en;
   assign rdata_o = state_r.rdata;
   assign irq_o = state_r.irq;

   // ==========================================================
   // checks
   sequence s_read_status;
      rd_i && addr_i == gpp_pkg::OFF_STATUS;
   endsequence

   sequence s_write_data;
      wr_i && addr_i == gpp_pkg::OFF_DATA;
   endsequence

   sequence s_read_data;
      rd_i && addr_i == gpp_pkg::OFF_DATA;
   endsequence

   sequence s_clear_write;
      wr_i && addr_i == gpp_pkg::OFF_IRQ_CLEAR;
   endsequence

   sequence s_clear_read;
      rd_i && addr_i == gpp_pkg::OFF_IRQ_CLEAR;
   endsequence

   sequence s_stat_write;
      wr_i && addr_i == gpp_pkg::OFF_IRQ_STAT;
   endsequence

   a_status_read: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      s_read_status |=> rdata_o == $past(pin_i))
      else $error("status read does not show pin level");

   // locked bits keep their old value, so only writable bits compare
   a_data_readback: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      s_write_data ##1 s_read_data |=>
      (rdata_o & wmask) == ($past(wdata_i, 2) & wmask))
      else $error("data readback differs from write");

   a_rdata_idle: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data outside its cycle");

   // pad outputs lag the state by one register, hence the past values
   a_push_pull: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      $past(state_r.mode[2:0] == gpp_pkg::drive_push_pull
      && !state_r.sync[0]) |-> pin_oe_o[0]
      && pin_out_o[0] == $past(state_r.data[0]))
      else $error("push pull pin not driven");

   a_od_low: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      $past(state_r.mode[2:0] == gpp_pkg::drive_open_drain_low
      && !state_r.sync[0] && state_r.data[0]) |-> !pin_oe_o[0])
      else $error("open drain low pin drives high");

   a_pull_up: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      $past(state_r.mode[2:0] == gpp_pkg::drive_resistive_pullup
      && !state_r.sync[0] && state_r.data[0])
      |-> pull_up_o[0] && !pin_oe_o[0])
      else $error("pull up pin not pulled");

   a_pull_down: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      $past(state_r.mode[2:0] == gpp_pkg::drive_resistive_pulldown
      && !state_r.sync[0] && !state_r.data[0])
      |-> pull_down_o[0] && !pin_oe_o[0])
      else $error("pull down pin not pulled");

   a_analog_off: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      $past(state_r.mode[2:0] == gpp_pkg::drive_analog_highz)
      |-> !in_en_o[0])
      else $error("analog pin still senses");

   a_clear_all: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      s_clear_write |=> state_r.stat == $past(event_v))
      else $error("clear left bits pending");

   a_clear_read: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      s_clear_read |=> rdata_o == $past(state_r.stat)
      && state_r.stat == $past(event_v))
      else $error("clear read lost status or left bits");

   a_event_sets: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      |event_v |=> (state_r.stat & $past(event_v)) == $past(event_v))
      else $error("event not latched");

   a_stat_w1c: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      s_stat_write |=> state_r.stat
      == (($past(state_r.stat) & ~$past(wdata_i)) | $past(event_v)))
      else $error("status write one clear wrong");

   a_irq_level: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      ##1 irq_o == |(state_r.stat & state_r.mask))
      else $error("irq does not follow status");

   a_irq_drop: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      s_clear_write ##0 !(|event_v) |=> !irq_o)
      else $error("irq stays high after clear");

   a_lock_top: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      LOCK_TOP |-> state_r.data[7:6] == 2'h0)
      else $error("locked pins changed");

   a_lock_mode: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      LOCK_TOP |-> state_r.mode[23:18] == 6'h00)
      else $error("locked pin modes changed");

   a_sync_delay: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      $past(state_r.sync[0]) |-> pin_out_o[0] == $past(state_r.dec.out[0]))
      else $error("synchronised output not delayed");

   a_sync_off: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      !$past(state_r.sync[0]) |-> pin_out_o[0] == $past(pad_comb.out[0]))
      else $error("unsynchronised output delayed");

endmodule : gpp_port

/* File: gpp_pin_model.sv */
// outside world of the port: pad controls plus an external source
// assumes one clock; levels move just after the rising edge
`timescale 1ns/10ps
module gpp_pin_model (
   input wire logic sys_clk_i,
   input wire logic [7:0] pin_out_i,
   input wire logic [7:0] pin_oe_i,
   input wire logic [7:0] pull_up_i,
   input wire logic [7:0] pull_down_i,
   input wire logic [7:0] ext_en_i,
   input wire logic [7:0] ext_val_i,
   output logic [7:0] pin_o
);
   // ==========================================
   // pin resolution
   // a floating pin flips every cycle so a stale level cannot pass
   initial pin_o = 8'h00;
   always @(posedge sys_clk_i) begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_i[i]) begin
            pin_o[i] <= pin_out_i[i];
         end else if (ext_en_i[i]) begin
            pin_o[i] <= ext_val_i[i];
         end else if (pull_up_i[i] && pull_down_i[i]) begin
            pin_o[i] <= pin_out_i[i];
         end else if (pull_up_i[i] || pull_down_i[i]) begin
            pin_o[i] <= pull_up_i[i];
         end else begin
            pin_o[i] <= ~pin_o[i];
         end
      end
   end
endmodule : gpp_pin_model

/* File: gpp_port_tb.sv */
// self-checking bench for the io port, top pins locked
// assumes the pin model answers one cycle after pad controls
`timescale 1ns/10ps
module gpp_port_tb;
   logic sys_clk, reset_n, wr, rd, irq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, pin_lvl, pin_out, pin_oe, pu, pd, in_en;
   logic [7:0] ext_en, ext_val, d, e;
   int num_errors, compares, lat0, lat1;

   gpp_port #(.LOCK_TOP(1'b1)) i_dut (.sys_clk_i(sys_clk),
      .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .pin_i(pin_lvl), .pin_out_o(pin_out),
      .pin_oe_o(pin_oe), .pull_up_o(pu), .pull_down_o(pd),
      .in_en_o(in_en), .irq_o(irq));
   gpp_pin_model i_pins (.sys_clk_i(sys_clk), .pin_out_i(pin_out),
      .pin_oe_i(pin_oe), .pull_up_i(pu), .pull_down_i(pd),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin_lvl));

   always #10 sys_clk = ~sys_clk;

   // ==========================================
   // bus and compare tasks
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      v = rdata;
   endtask : rd_reg
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd_reg(a, v);
      check(v, exp);
   endtask : rd_chk
   task automatic set_mode(input logic [2:0] m);
      wr_reg(gpp_pkg::OFF_MODE_LO, {8{m[0]}});
      wr_reg(gpp_pkg::OFF_MODE_HI, {8{m[1]}});
      wr_reg(gpp_pkg::OFF_MODE_TOP, {8{m[2]}});
   endtask : set_mode
   // counts cycles from the write until pin 0 follows it
   task automatic lat(input logic [7:0] v, output int n);
      wr_reg(gpp_pkg::OFF_DATA, v);
      #1;
      n = 0;
      while (pin_out[0] !== v[0] && n < 10) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask : lat
   task finish_test;
      if (num_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // ==========================================
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      finish_test;
   end

   // ==========================================
   // tests
   initial begin
      sys_clk = 1'b0;
      reset_n = 1'b0;
      {addr, wdata, wr, rd} = '0;
      ext_en = 8'hFF;
      ext_val = 8'h00;
      num_errors = 0;
      compares = 0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      check(in_en, 8'h00);
      for (int a = 0; a < 16; a++) begin
         if (a != 1) rd_chk(a[3:0], 8'h00);
      end
      wr_reg(4'hF, 8'hFF);
      rd_chk(4'hF, 8'h00);
      wr_reg(gpp_pkg::OFF_DATA, 8'hFF);
      rd_chk(gpp_pkg::OFF_DATA, 8'h3F);
      wr_reg(gpp_pkg::OFF_DATA, 8'hA5);
      rd_chk(gpp_pkg::OFF_DATA, 8'h25);
      // read data stand for one cycle only
      @(negedge sys_clk);
      check(rdata, 8'h00);
      // open drain needs an outside level on its released side
      for (int m = 0; m < 8; m++) begin
         ext_en <= (m == 1 || m == 4 || m == 5) ? 8'hFF : 8'h00;
         ext_val <= (m == 1) ? 8'h3C : (m == 4) ? 8'hFF : 8'h00;
         set_mode(m[2:0]);
         repeat (4) @(posedge sys_clk);
         check(in_en, (m == 0) ? 8'h00 : 8'h3F);
         if (m == 2) check(pu, 8'h25);
         if (m == 3) check(pd, 8'h1A);
         e = (m == 1) ? 8'h3C : 8'h25;
         rd_reg(gpp_pkg::OFF_STATUS, d);
         if (m != 0) check(d & 8'h3F, e);
         if (m == 6) check(pin_oe, 8'h3F);
         if (m == 1) check(pin_oe, 8'h00);
         rd_chk(gpp_pkg::OFF_MODE_LO, m[0] ? 8'h3F : 8'h00);
      end
      rd_reg(gpp_pkg::OFF_DATA, d);
      wr_reg(gpp_pkg::OFF_DATA, d | 8'h02);
      rd_chk(gpp_pkg::OFF_DATA, 8'h27);
      set_mode(3'h6);
      lat(8'h26, lat0);
      wr_reg(gpp_pkg::OFF_SYNC, 8'hFF);
      lat(8'h27, lat1);
      check(8'(lat1 - lat0), 8'h01);
      wr_reg(gpp_pkg::OFF_SYNC, 8'h00);
      // events on rising edges, then falling
      ext_en <= 8'hFF;
      set_mode(3'h1);
      wr_reg(gpp_pkg::OFF_IRQ_CLEAR, 8'h00);
      @(posedge sys_clk) ext_val <= 8'h05;
      repeat (4) @(posedge sys_clk);
      rd_chk(gpp_pkg::OFF_IRQ_STAT, 8'h05);
      check({7'h00, irq}, 8'h00);
      wr_reg(gpp_pkg::OFF_IRQ_MASK, 8'h04);
      repeat (2) @(posedge sys_clk);
      check({7'h00, irq}, 8'h01);
      wr_reg(gpp_pkg::OFF_IRQ_STAT, 8'h04);
      rd_chk(gpp_pkg::OFF_IRQ_STAT, 8'h01);
      check({7'h00, irq}, 8'h00);
      wr_reg(gpp_pkg::OFF_EDGE_SEL, 8'hFF);
      @(posedge sys_clk) ext_val <= 8'h00;
      repeat (4) @(posedge sys_clk);
      rd_chk(gpp_pkg::OFF_IRQ_CLEAR, 8'h05);
      rd_chk(gpp_pkg::OFF_IRQ_STAT, 8'h00);
      @(posedge sys_clk) ext_val <= 8'h05;
      repeat (4) @(posedge sys_clk);
      rd_chk(gpp_pkg::OFF_IRQ_STAT, 8'h00);
      @(posedge sys_clk) ext_val <= 8'h00;
      repeat (4) @(posedge sys_clk);
      check({7'h00, irq}, 8'h01);
      wr_reg(gpp_pkg::OFF_IRQ_CLEAR, 8'h00);
      rd_chk(gpp_pkg::OFF_IRQ_STAT, 8'h00);
      check({7'h00, irq}, 8'h00);
      finish_test;
   end
endmodule : gpp_port_tb
